// >>> hdl/scp_pkg.sv
package scp_pkg;

  // frame layout: 8 instruction bits then 8 data bits, msb first
  localparam int SCP_FRAME_BITS = 16;
  localparam int SCP_INSTR_BITS = 8;
  localparam int SCP_DATA_BITS = 8;
  localparam int SCP_CNT_W = 5;
  localparam logic [SCP_CNT_W-1:0] SCP_CNT_INSTR_LAST = 5'h07;
  localparam logic [SCP_CNT_W-1:0] SCP_CNT_DATA_FIRST = 5'h08;
  localparam logic [SCP_CNT_W-1:0] SCP_CNT_LAST = 5'h0F;
  localparam logic [SCP_CNT_W-1:0] SCP_CNT_DONE = 5'h10;

  // instruction fields
  localparam int SCP_RW_BIT = 7;

  // wiring mode register and its field
  localparam int SCP_MODE_REG = 0;
  localparam int SCP_MODE_BIT = 7;

  // values after reset
  localparam logic [SCP_DATA_BITS-1:0] SCP_REG_RST = 8'h00;
  localparam logic SCP_PIN_RST = 1'h1;
  localparam logic SCP_TGL_RST = 1'h0;
  localparam logic SCP_MODE_RST = 1'h0;

  // cross-domain filter: reset pin, write toggle, wiring mode
  localparam int SCP_SYNC_N = 3;
  localparam int SCP_SYNC_PIN = 2;
  localparam int SCP_SYNC_TGL = 1;
  localparam int SCP_SYNC_MODE = 0;
  localparam logic [SCP_SYNC_N-1:0] SCP_SYNC_RST = 3'h4;

  typedef struct packed {
    logic o;
    logic oe;
  } scp_drive_t;

endpackage : scp_pkg

// >>> hdl/scp_port.sv
`timescale 1ns/100ps
`default_nettype none

module scp_port
  import scp_pkg::*;
#(
  parameter int ADDR_W = 3
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdio_i,
  input wire logic chip_reset_n,
  output var scp_drive_t sdio_drv,
  output var scp_drive_t serial_out_line_drv,
  output logic chip_reset_active,
  output logic cfg_four_wire,
  output logic cfg_update,
  output logic [(1<<ADDR_W)*SCP_DATA_BITS-1:0] cfg_regs
);

  localparam int NREG = 1 << ADDR_W;

  // ---------------- main clock domain ----------------
  logic chip_rst_r;
  logic [SCP_SYNC_N-1:0] sync1_r;
  logic [SCP_SYNC_N-1:0] sync2_r;
  logic [SCP_SYNC_N-1:0] sync3_r;
  logic [SCP_SYNC_N-1:0] stable_r;
  logic [SCP_SYNC_N-1:0] stable_nxt;
  logic cfg_update_r;
  logic [NREG*SCP_DATA_BITS-1:0] cfg_regs_r;

  // ---------------- link clock domain ----------------
  logic [SCP_CNT_W-1:0] bit_cnt_r;
  logic [SCP_INSTR_BITS-1:0] shift_r;
  logic [SCP_INSTR_BITS-1:0] instr_r;
  logic rd_r;
  logic [SCP_DATA_BITS-1:0] rd_word_r;
  logic [SCP_DATA_BITS-1:0] regs_r [NREG];
  logic wr_tgl_r;
  logic four_wire;
  scp_drive_t sdio_drv_r;
  scp_drive_t sdo_drv_r;

  wire logic frame_arst = serial_select_n | chip_rst_r;
  wire logic [SCP_INSTR_BITS-1:0] instr_now = {shift_r[6:0], sdio_i};
  wire logic [SCP_DATA_BITS-1:0] data_now = {shift_r[6:0], sdio_i};
  wire logic [ADDR_W-1:0] addr_now = instr_now[ADDR_W-1:0];
  wire logic [ADDR_W-1:0] addr_r = instr_r[ADDR_W-1:0];
  wire logic instr_end = bit_cnt_r == SCP_CNT_INSTR_LAST;
  wire logic wr_fire = (bit_cnt_r == SCP_CNT_LAST) && !instr_r[SCP_RW_BIT];
  wire logic in_data = (bit_cnt_r >= SCP_CNT_DATA_FIRST) &&
                       (bit_cnt_r <= SCP_CNT_LAST);
  wire logic rd_drive = rd_r && in_data;
  wire logic [2:0] rd_idx = 3'(SCP_CNT_LAST - bit_cnt_r);
  wire logic rd_bit = rd_word_r[rd_idx];
  wire logic [SCP_SYNC_N-1:0] sync_in = {chip_reset_n, wr_tgl_r, four_wire};
  wire logic tgl_event = stable_nxt[SCP_SYNC_TGL] != stable_r[SCP_SYNC_TGL];

  // mode field, cleared by chip reset
  assign four_wire = regs_r[SCP_MODE_REG][SCP_MODE_BIT];

  // three flops; a change counts once the second and third agree
  genvar g;
  generate
    for (g = 0; g < SCP_SYNC_N; g++) begin : g_sync
      assign stable_nxt[g] = (sync2_r[g] == sync3_r[g]) ? sync3_r[g] :
                             stable_r[g];
      always_ff @(posedge clk) begin
        if (!rstn) begin
          sync1_r[g] <= SCP_SYNC_RST[g];
          sync2_r[g] <= SCP_SYNC_RST[g];
          sync3_r[g] <= SCP_SYNC_RST[g];
          stable_r[g] <= SCP_SYNC_RST[g];
        end else begin
          sync1_r[g] <= sync_in[g];
          sync2_r[g] <= sync1_r[g];
          sync3_r[g] <= sync2_r[g];
          stable_r[g] <= stable_nxt[g];
        end
      end
    end
  endgenerate

  // pin low or system reset holds chip reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      chip_rst_r <= 1'h1;
    end else begin
      chip_rst_r <= !stable_nxt[SCP_SYNC_PIN];
    end
  end

  // regs are quiet for a whole frame after the toggle, so copying is safe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_update_r <= 1'h0;
      cfg_regs_r <= '0;
    end else begin
      cfg_update_r <= tgl_event;
      if (tgl_event) begin
        for (int i = 0; i < NREG; i++) begin
          cfg_regs_r[i*SCP_DATA_BITS +: SCP_DATA_BITS] <= regs_r[i];
        end
      end
    end
  end

  // select acts as an asynchronous reset, ends the frame
  always_ff @(posedge sclk or posedge frame_arst) begin
    if (frame_arst) begin
      bit_cnt_r <= '0;
      shift_r <= '0;
      instr_r <= '0;
      rd_r <= 1'h0;
      rd_word_r <= '0;
    end else begin
      if (bit_cnt_r != SCP_CNT_DONE) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
      shift_r <= instr_now;
      if (instr_end) begin
        instr_r <= instr_now;
        rd_r <= instr_now[SCP_RW_BIT];
        rd_word_r <= regs_r[addr_now];
      end
    end
  end

  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      always_ff @(posedge sclk or posedge chip_rst_r) begin
        if (chip_rst_r) begin
          regs_r[g] <= SCP_REG_RST;
        end else if (wr_fire && addr_r == ADDR_W'(g)) begin
          regs_r[g] <= data_now;
        end
      end
    end
  endgenerate

  always_ff @(posedge sclk or posedge chip_rst_r) begin
    if (chip_rst_r) begin
      wr_tgl_r <= SCP_TGL_RST;
    end else if (wr_fire) begin
      wr_tgl_r <= !wr_tgl_r;
    end
  end

  // falling edge launch gives the host a half period of setup
  always_ff @(negedge sclk or posedge frame_arst) begin
    if (frame_arst) begin
      sdio_drv_r <= '0;
      sdo_drv_r <= '0;
    end else begin
      sdio_drv_r.oe <= rd_drive && !four_wire;
      sdio_drv_r.o <= rd_drive && !four_wire && rd_bit;
      sdo_drv_r.oe <= rd_drive && four_wire;
      sdo_drv_r.o <= rd_drive && four_wire && rd_bit;
    end
  end

  assign sdio_drv = sdio_drv_r;
  assign serial_out_line_drv = sdo_drv_r;
  assign chip_reset_active = chip_rst_r;
  assign cfg_four_wire = stable_r[SCP_SYNC_MODE];
  assign cfg_update = cfg_update_r;
  assign cfg_regs = cfg_regs_r;

  // ---------------- checks ----------------
  // the bit seen at a rising edge was launched under the same count
  wire logic [2:0] chk_idx = 3'(SCP_CNT_LAST - bit_cnt_r);
  wire logic chk_window = rd_r && (bit_cnt_r >= SCP_CNT_DATA_FIRST) &&
                          (bit_cnt_r <= SCP_CNT_LAST);

  property p_three_wire_read;
    @(posedge sclk) disable iff (frame_arst)
      chk_window && !four_wire |->
        sdio_drv_r.oe && sdio_drv_r.o == rd_word_r[chk_idx];
  endproperty
  a_three_wire_read: assert property (p_three_wire_read)
    else $error("data line not driving read bit in three-wire mode");

  property p_four_wire_input;
    @(posedge sclk) disable iff (frame_arst)
      four_wire |-> !sdio_drv_r.oe;
  endproperty
  a_four_wire_input: assert property (p_four_wire_input)
    else $error("data line driven in four-wire mode");

  property p_mode_after_reset;
    @(posedge clk) disable iff (!rstn)
      chip_rst_r [*5] |-> !four_wire && !cfg_four_wire;
  endproperty
  a_mode_after_reset: assert property (p_mode_after_reset)
    else $error("four-wire mode survived chip reset");

  property p_four_wire_read;
    @(posedge sclk) disable iff (frame_arst)
      chk_window && four_wire |->
        serial_out_line_drv.oe &&
        serial_out_line_drv.o == rd_word_r[chk_idx];
  endproperty
  a_four_wire_read: assert property (p_four_wire_read)
    else $error("dedicated output missing read bit in four-wire mode");

  property p_reset_pin;
    @(posedge clk) disable iff (!rstn)
      !chip_reset_n [*3] ##1 !chip_reset_n |-> ##[1:2] chip_rst_r;
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("reset pin low without chip reset");

  property p_reset_release;
    @(posedge clk) disable iff (!rstn)
      chip_reset_n [*5] |-> !chip_rst_r;
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("chip reset held with pin high");

  property p_sdo_idle_select;
    @(posedge clk) disable iff (!rstn)
      serial_select_n ##1 serial_select_n |-> !serial_out_line_drv.oe;
  endproperty
  a_sdo_idle_select: assert property (p_sdo_idle_select)
    else $error("dedicated output driven while deselected");

  property p_sdo_idle_write;
    @(posedge sclk) disable iff (frame_arst)
      !rd_r || !four_wire |-> !serial_out_line_drv.oe;
  endproperty
  a_sdo_idle_write: assert property (p_sdo_idle_write)
    else $error("dedicated output driven outside a read");

  property p_write_update;
    @(posedge clk) disable iff (!rstn)
      tgl_event |=> cfg_update;
  endproperty
  a_write_update: assert property (p_write_update)
    else $error("write toggle without update pulse");

  property p_select_clears;
    @(posedge clk) disable iff (!rstn)
      serial_select_n |-> bit_cnt_r == '0 && !rd_r;
  endproperty
  a_select_clears: assert property (p_select_clears)
    else $error("frame state kept while deselected");

  property p_sdio_idle_select;
    @(posedge clk) disable iff (!rstn)
      serial_select_n |-> !sdio_drv.oe;
  endproperty
  a_sdio_idle_select: assert property (p_sdio_idle_select)
    else $error("data line driven while deselected");

  property p_instr_quiet;
    @(posedge sclk) disable iff (frame_arst)
      bit_cnt_r < SCP_CNT_DATA_FIRST |->
        !sdio_drv_r.oe && !serial_out_line_drv.oe;
  endproperty
  a_instr_quiet: assert property (p_instr_quiet)
    else $error("device drove a line during instruction bits");

  property p_sdio_read_only;
    @(posedge sclk) disable iff (frame_arst)
      sdio_drv_r.oe |-> rd_r && !four_wire;
  endproperty
  a_sdio_read_only: assert property (p_sdio_read_only)
    else $error("data line driven outside a three-wire read");

  property p_reset_quiet;
    @(posedge clk) disable iff (!rstn)
      chip_rst_r |-> !sdio_drv.oe && !serial_out_line_drv.oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("line driven during chip reset");

  property p_reset_regs;
    @(posedge clk) disable iff (!rstn)
      chip_rst_r |-> !wr_tgl_r && regs_r[SCP_MODE_REG] == SCP_REG_RST;
  endproperty
  a_reset_regs: assert property (p_reset_regs)
    else $error("link registers kept during chip reset");

  property p_sdo_quiet_low;
    @(posedge clk) disable iff (!rstn)
      !serial_out_line_drv.oe |-> !serial_out_line_drv.o;
  endproperty
  a_sdo_quiet_low: assert property (p_sdo_quiet_low)
    else $error("stale data on released dedicated output");

endmodule : scp_port

`default_nettype wire

// >>> tb/scp_host.sv
`timescale 1ns/100ps
`default_nettype none

module scp_host
  import scp_pkg::*;
(
  output logic sclk,
  output logic serial_select_n,
  output scp_drive_t host_drv,
  input wire logic sdio_line,
  input wire logic sdo_line,
  input wire scp_drive_t dev_sdio,
  input wire scp_drive_t dev_sdo
);
  initial begin
    sclk = 1'b0;
    serial_select_n = 1'b1;
    host_drv = '0;
  end

  // sclk stands still between frames; nbits below 16 cuts a frame short
  task xfer(input logic [15:0] frm, input int nbits, input logic four,
            output logic [7:0] rd, output logic stray);
    int i;
    rd = 8'h00;
    stray = 1'b0;
    serial_select_n = 1'b0;
    for (i = 0; i < nbits; i++) begin
      host_drv.oe = !(frm[15] && i > 7);
      host_drv.o = frm[15-i];
      #32 sclk = 1'b1;
      if (i > 7) begin
        rd[15-i] = four ? sdo_line : sdio_line;
      end
      stray |= four ? dev_sdio.oe : dev_sdo.oe;
      #32 sclk = 1'b0;
    end
    host_drv = '0;
    serial_select_n = 1'b1;
    #64;
  endtask : xfer
endmodule : scp_host

`default_nettype wire

// >>> tb/scp_port_test.sv
`timescale 1ns/100ps
`default_nettype none

module scp_port_test;
  import scp_pkg::*;
  logic clk, rstn, chip_reset_n, sclk, serial_select_n, junk, stray;
  logic cfg_four_wire, cfg_update, chip_reset_active;
  wire logic sdio_line, sdo_line;
  scp_drive_t host_drv, sdio_drv, sdo_drv;
  logic [63:0] cfg_regs;
  logic [7:0] model [8];
  logic [7:0] rd;
  int bad_count, compares, seed, k;

  // undriven data line shows a changing pattern, not a held value
  assign sdio_line = sdio_drv.oe ? sdio_drv.o : host_drv.oe ? host_drv.o : junk;
  assign sdo_line = sdo_drv.oe ? sdo_drv.o : 1'bz;

  scp_port #(.ADDR_W(3)) i_dut (.clk(clk), .rstn(rstn), .sclk(sclk),
    .serial_select_n(serial_select_n), .sdio_i(sdio_line),
    .chip_reset_n(chip_reset_n), .sdio_drv(sdio_drv),
    .serial_out_line_drv(sdo_drv), .chip_reset_active(chip_reset_active),
    .cfg_four_wire(cfg_four_wire), .cfg_update(cfg_update),
    .cfg_regs(cfg_regs));
  scp_host i_host (.sclk(sclk), .serial_select_n(serial_select_n),
    .host_drv(host_drv), .sdio_line(sdio_line), .sdo_line(sdo_line),
    .dev_sdio(sdio_drv), .dev_sdo(sdo_drv));

  initial begin
    clk = 1'b0;
    junk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) junk <= ~junk;

  task check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task wait_ready;
    k = 0;
    while (chip_reset_active !== 1'b0 && k < 40) begin
      @(negedge clk);
      k++;
    end
    #64;
  endtask : wait_ready

  task wr(input int a, input logic [7:0] d);
    int n;
    i_host.xfer({5'h00, a[2:0], d}, 16, model[0][7], rd, stray);
    model[a] = d;
    n = 0;
    while (cfg_update !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("cfg_update", 8'h01, {7'h00, cfg_update});
    check("cfg_regs", model[a], cfg_regs[a*8 +: 8]);
  endtask : wr

  task rdk(input int a);
    i_host.xfer({5'h10, a[2:0], 8'h00}, 16, model[0][7], rd, stray);
    check("read data", model[a], rd);
    check("other line enable", 8'h00, {7'h00, stray});
  endtask : rdk

  initial begin
    rstn = 1'b0;
    chip_reset_n = 1'b1;
    bad_count = 0;
    compares = 0;
    seed = 93;
    for (int i = 0; i < 8; i++) model[i] = 8'h00;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    wait_ready();
    check("four wire", 8'h00, {7'h00, cfg_four_wire});
    check("out enable", 8'h00, {7'h00, sdo_drv.oe});
    for (int i = 1; i < 8; i++) wr(i, 8'($random(seed)));
    for (int i = 0; i < 8; i++) rdk(i);
    wr(0, 8'h80);
    check("four wire", 8'h01, {7'h00, cfg_four_wire});
    for (int i = 0; i < 8; i++) rdk(i);
    i_host.xfer({5'h00, 3'h5, 8'hA5}, 10, 1'b1, rd, stray);
    rdk(5);
    i_host.xfer({5'h10, 3'h3, 8'h00}, 12, 1'b1, rd, stray);
    check("out enable", 8'h00, {7'h00, sdo_drv.oe});
    @(negedge clk);
    chip_reset_n = 1'b0;
    repeat (8) @(negedge clk);
    check("chip reset", 8'h01, {7'h00, chip_reset_active});
    chip_reset_n = 1'b1;
    wait_ready();
    for (int i = 0; i < 8; i++) model[i] = 8'h00;
    check("four wire", 8'h00, {7'h00, cfg_four_wire});
    for (int i = 0; i < 8; i++) rdk(i);
    tally_and_finish();
  end

  initial begin
    #300000;
    bad_count++;
    tally_and_finish();
  end
endmodule : scp_port_test

`default_nettype wire
